// file: logic/uart_rx_frame_and_baud_divider.v
// uart receive framing, fractional baud divisor and receive buffer behind an avalon-mm slave
// assumes rx_serial_i is asynchronous to clock_i, the uart reference clock; bus runs on clock_i
//
// Behaviour
// RULE_01: parity checked only when enabled; even-select ignored while parity is off.
// RULE_02: even-select 0 requires odd ones over data plus parity, else parity fault.
// RULE_03: even-select 1 requires even ones over data plus parity, else parity fault.
// RULE_04: stick parity expects 0 under even, 1 under odd; cleared means normal.
// RULE_05: two-stop control 0 checks one stop bit, 1 checks two.
// RULE_06: fifo enable 0 gives one holding register, 1 buffers in receive fifo.
// RULE_07: word length 00 five, 01 six, 10 seven, 11 eight data bits.
// RULE_08: divisor counts reference clock per 16x or 8x oversample tick.
// RULE_09: divisor has 16-bit integer and 6-bit fraction; upper bits reserved.
// RULE_10: new divisor used only after the current character completes.
// RULE_11: empty flag shows holding register or fifo empty; resets to one.
// RULE_12: fraction is sixty-fourths, accumulated so average tick matches divisor.
// RULE_13: each bit sampled near centre of its oversampled period.
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_defs.vh"

module uart_rx_frame_and_baud_divider #(
  parameter FIFO_DEPTH = 16,
  parameter PTR_WIDTH = 4
) (
  input wire clock_i,
  input wire sys_rst_i,
  input wire [5:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [3:0] avs_byteenable_i,
  input wire [31:0] avs_writedata_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  input wire rx_serial_i,
  output reg rx_empty_o
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // byte-lane merge of a write into an old word
  function [31:0] merge_lanes;
    input [31:0] old_word;
    input [31:0] new_word;
    input [3:0] lanes;
    integer k;
    begin
      merge_lanes = old_word;
      for (k = 0; k < 4; k = k + 1) begin
        if (lanes[k]) begin
          merge_lanes[k*8 +: 8] = new_word[k*8 +: 8];
        end
      end
    end
  endfunction

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_START = 3'd1;
  localparam [2:0] ST_DATA = 3'd2;
  localparam [2:0] ST_PARITY = 3'd3;
  localparam [2:0] ST_STOP = 3'd4;

  // ----------------------------------------
  // registers seen by software, the pending swap flag and the active divisor copies
  // ----------------------------------------
  reg [`LC_WIDTH-1:0] rx_line_control;
  reg [`DIV_INT_WIDTH-1:0] baud_divisor_integer;
  reg [`DIV_FRAC_WIDTH-1:0] baud_divisor_fraction;
  reg oversample_select;
  reg div_pending;
  reg [`DIV_INT_WIDTH-1:0] div_int_active;
  reg [`DIV_FRAC_WIDTH-1:0] div_frac_active;

  wire rx_parity_enable = rx_line_control[`LC_PARITY_ENABLE];
  wire rx_even_select = rx_line_control[`LC_EVEN_SELECT];
  wire rx_two_stop_select = rx_line_control[`LC_TWO_STOP];
  wire rx_fifo_enable = rx_line_control[`LC_FIFO_ENABLE];
  wire [1:0] rx_word_length = rx_line_control[`LC_WLEN_MSB:`LC_WLEN_LSB];
  wire rx_stick_parity = rx_line_control[`LC_STICK_PARITY];

  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  wire req = avs_read_i | avs_write_i;
  wire accept = req & ~avs_waitrequest_o;
  wire wr_accept = accept & avs_write_i;
  wire rd_accept = accept & avs_read_i;
  wire div_wr = wr_accept && (avs_address_i == `OFS_DIV_INTEGER || avs_address_i == `OFS_DIV_FRACTION);

  // fifo state, declared early for the read mux
  reg [9:0] fifo_mem [0:FIFO_DEPTH-1];
  reg [PTR_WIDTH-1:0] wr_ptr;
  reg [PTR_WIDTH-1:0] rd_ptr;
  reg [PTR_WIDTH:0] fill;
  wire [PTR_WIDTH:0] capacity = rx_fifo_enable ? FIFO_DEPTH[PTR_WIDTH:0] : {{PTR_WIDTH{1'b0}}, 1'b1}; // [RULE_06]
  wire buf_empty = (fill == {(PTR_WIDTH+1){1'b0}});
  wire buf_full = (fill >= capacity);

  // read data mux, unmapped offsets read as zero
  reg [31:0] next_readdata;
  always @* begin
    next_readdata = 32'h00000000;
    case (avs_address_i)
      `OFS_RX_DATA: next_readdata = buf_empty ? 32'h00000000 : {22'h0, fifo_mem[rd_ptr]};
      `OFS_STATUS: next_readdata = ({31'h0, buf_empty} << `ST_RX_EMPTY) | ({31'h0, buf_full} << `ST_RX_FULL);
      `OFS_RX_LINE_CONTROL: next_readdata = {{(32-`LC_WIDTH){1'b0}}, rx_line_control};
      `OFS_DIV_INTEGER: next_readdata = {16'h0, baud_divisor_integer};
      `OFS_DIV_FRACTION: next_readdata = {26'h0, baud_divisor_fraction};
      `OFS_UART_CONTROL: next_readdata = {31'h0, oversample_select};
      default: next_readdata = 32'h00000000;
    endcase
  end

  // one wait cycle per request: waitrequest drops for the accepting edge only
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h00000000;
    end else begin
      avs_waitrequest_o <= ~(req & avs_waitrequest_o);
      if (req & avs_waitrequest_o & avs_read_i) begin
        avs_readdata_o <= next_readdata;
      end
    end
  end

  // register writes merge lanes into the word the read mux shows; reserved bits are dropped so they read as zero
  wire [31:0] merged = merge_lanes(next_readdata, avs_writedata_i, avs_byteenable_i);

  reg [2:0] state;
  wire rx_idle = (state == ST_IDLE);
  wire div_swap = div_pending && rx_idle && !div_wr;

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      rx_line_control <= `RST_RX_LINE_CONTROL;
      baud_divisor_integer <= `RST_DIV_INTEGER;
      baud_divisor_fraction <= `RST_DIV_FRACTION;
      oversample_select <= `RST_UART_CONTROL;
      div_pending <= 1'b0;
      div_int_active <= `RST_DIV_INTEGER;
      div_frac_active <= `RST_DIV_FRACTION;
    end else begin
      if (wr_accept) begin
        case (avs_address_i)
          `OFS_RX_LINE_CONTROL: rx_line_control <= {merged[`LC_WIDTH-1:1], 1'b0}; // bit 0 is reserved
          `OFS_DIV_INTEGER: baud_divisor_integer <= merged[`DIV_INT_WIDTH-1:0]; // [RULE_09]
          `OFS_DIV_FRACTION: baud_divisor_fraction <= merged[`DIV_FRAC_WIDTH-1:0]; // [RULE_09]
          `OFS_UART_CONTROL: oversample_select <= merged[`CTL_OVERSAMPLE];
          default: rx_line_control <= rx_line_control;
        endcase
      end
      // a divisor write arms a swap; the swap waits for the line to go idle
      if (div_wr) begin
        div_pending <= 1'b1;
      end else if (div_swap) begin
        div_pending <= 1'b0; // [RULE_10]
        div_int_active <= baud_divisor_integer;
        div_frac_active <= baud_divisor_fraction;
      end
    end
  end

  // ----------------------------------------
  // fractional baud tick generator
  // ----------------------------------------
  // each tick spans the integer count plus one extra cycle whenever the
  // sixty-fourths accumulator overflows, so the mean period is exact
  reg [`DIV_INT_WIDTH-1:0] tick_cnt;
  reg [`DIV_FRAC_WIDTH-1:0] frac_acc;
  reg os_tick;
  wire [`DIV_FRAC_WIDTH:0] acc_sum = {1'b0, frac_acc} + {1'b0, div_frac_active};

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      tick_cnt <= 16'h0000;
      frac_acc <= 6'h00;
      os_tick <= 1'b0;
    end else begin
      os_tick <= 1'b0;
      if (div_swap) begin
        tick_cnt <= 16'h0000; // restart, a long count left from the old rate would stall it [RULE_10]
        frac_acc <= 6'h00;
      end else if (div_int_active != 16'h0000) begin
        if (tick_cnt == 16'h0000) begin
          os_tick <= 1'b1; // [RULE_08]
          frac_acc <= acc_sum[`DIV_FRAC_WIDTH-1:0]; // [RULE_12]
          tick_cnt <= div_int_active - 16'h0001 + {15'h0000, acc_sum[`DIV_FRAC_WIDTH]}; // [RULE_12]
        end else begin
          tick_cnt <= tick_cnt - 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------
  // serial input synchroniser
  // ----------------------------------------
  reg rx_meta;
  reg rx_sync;
  reg rx_prev;
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_meta <= rx_serial_i;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  // ----------------------------------------
  // receive frame state machine
  // ----------------------------------------
  reg [3:0] os_cnt;
  reg [2:0] bit_idx;
  reg [7:0] shreg;
  reg par_bit;
  reg stop_idx;
  reg frame_err;
  reg push;
  wire [3:0] os_last = oversample_select ? `OS_LAST_8X : `OS_LAST_16X; // [RULE_08]
  wire [3:0] os_half = {1'b0, os_last[3:1]};
  wire [2:0] last_bit = {1'b1, rx_word_length}; // [RULE_07]
  wire bit_centre = os_tick && (os_cnt == os_last);

  // unused upper data bits are zero, so a full xor covers any word length
  wire par_xor = (^shreg) ^ par_bit;
  wire stick_bad = (par_bit != ~rx_even_select); // [RULE_04]
  wire norm_bad = rx_even_select ? par_xor : ~par_xor; // [RULE_02] [RULE_03]
  wire par_fault = rx_parity_enable & (rx_stick_parity ? stick_bad : norm_bad); // [RULE_01]

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      state <= ST_IDLE;
      os_cnt <= 4'h0;
      bit_idx <= 3'd0;
      shreg <= 8'h00;
      par_bit <= 1'b0;
      stop_idx <= 1'b0;
      frame_err <= 1'b0;
      push <= 1'b0;
    end else begin
      push <= 1'b0;
      if (os_tick && !bit_centre && state != ST_IDLE) begin
        os_cnt <= os_cnt + 4'h1;
      end
      case (state)
        ST_IDLE: begin
          if (!rx_sync && rx_prev) begin // edge only: a low stop bit must not restart a frame
            state <= ST_START;
            os_cnt <= 4'h0;
          end
        end
        ST_START: begin
          // confirm the start bit at its centre to reject glitches
          if (os_tick && os_cnt == os_half) begin // [RULE_13]
            os_cnt <= 4'h0;
            bit_idx <= 3'd0;
            shreg <= 8'h00;
            frame_err <= 1'b0;
            par_bit <= 1'b0;
            state <= rx_sync ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (bit_centre) begin // [RULE_13]
            os_cnt <= 4'h0;
            shreg[bit_idx] <= rx_sync;
            bit_idx <= bit_idx + 3'd1;
            if (bit_idx == last_bit) begin // [RULE_07]
              stop_idx <= 1'b0;
              state <= rx_parity_enable ? ST_PARITY : ST_STOP; // [RULE_01]
            end
          end
        end
        ST_PARITY: begin
          if (bit_centre) begin
            os_cnt <= 4'h0;
            par_bit <= rx_sync;
            state <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (bit_centre) begin
            os_cnt <= 4'h0;
            frame_err <= frame_err | ~rx_sync;
            if (rx_two_stop_select && !stop_idx) begin // [RULE_05]
              stop_idx <= 1'b1;
            end else begin
              push <= 1'b1;
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // receive buffer
  // ----------------------------------------
  // the word is written one cycle after the last stop sample so that the
  // stop-bit error flag is already settled; a full buffer drops the word
  wire pop = rd_accept && (avs_address_i == `OFS_RX_DATA) && !buf_empty;
  wire do_push = push && !buf_full;
  wire [9:0] rx_word = {par_fault, frame_err, shreg};

  // storage is not reset; fill alone says which words are valid
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      wr_ptr <= {PTR_WIDTH{1'b0}};
      rd_ptr <= {PTR_WIDTH{1'b0}};
      fill <= {(PTR_WIDTH+1){1'b0}};
      rx_empty_o <= `RST_RX_EMPTY;
    end else begin
      if (do_push) begin
        fifo_mem[wr_ptr] <= rx_word;
        wr_ptr <= wr_ptr + {{(PTR_WIDTH-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr <= rd_ptr + {{(PTR_WIDTH-1){1'b0}}, 1'b1};
      end
      if (do_push && !pop) begin
        fill <= fill + {{PTR_WIDTH{1'b0}}, 1'b1};
      end else if (pop && !do_push) begin
        fill <= fill - {{PTR_WIDTH{1'b0}}, 1'b1};
      end
      // empty follows the buffer in either mode
      rx_empty_o <= !do_push && (buf_empty || (fill == {{PTR_WIDTH{1'b0}}, 1'b1} && pop)); // [RULE_11]
    end
  end

endmodule
`default_nettype wire

// file: pkg/uart_rx_defs.vh
// register offsets, field positions, reset values and timing for the uart receive block
// assumes byte addresses on a 32-bit avalon-mm slave port
`ifndef UART_RX_DEFS_VH
`define UART_RX_DEFS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_RX_DATA 6'h00
`define OFS_STATUS 6'h18
`define OFS_RX_LINE_CONTROL 6'h1C
`define OFS_DIV_INTEGER 6'h24
`define OFS_DIV_FRACTION 6'h28
`define OFS_UART_CONTROL 6'h30

// ----------------------------------------
// field positions
// ----------------------------------------
`define LC_PARITY_ENABLE 1
`define LC_EVEN_SELECT 2
`define LC_TWO_STOP 3
`define LC_FIFO_ENABLE 4
`define LC_WLEN_LSB 5
`define LC_WLEN_MSB 6
`define LC_STICK_PARITY 7
`define LC_WIDTH 8
`define CTL_OVERSAMPLE 0
`define ST_RX_EMPTY 4
`define ST_RX_FULL 6
`define DATA_FRAMING_ERR 8
`define DATA_PARITY_ERR 9
`define DIV_INT_WIDTH 16
`define DIV_FRAC_WIDTH 6

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_RX_LINE_CONTROL 8'h00
`define RST_DIV_INTEGER 16'h0000
`define RST_DIV_FRACTION 6'h00
`define RST_UART_CONTROL 1'b0
`define RST_RX_EMPTY 1'b1

// ----------------------------------------
// oversampling counts, last tick index of a bit
// ----------------------------------------
`define OS_LAST_16X 4'hF
`define OS_LAST_8X 4'h7

`endif

// file: testbench/uart_rx_checker_asserts.sv
// concurrent checks on bus answer timing, reserved bits and empty flag
// assumes binding to the receive block and seeing its ports only
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_defs.vh"
module uart_rx_checker (
  input wire clock_i,
  input wire sys_rst_i,
  input wire [5:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  input wire rx_empty_o
);
  // ----------------------------------------
  // helpers and timing
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // a read answered in this cycle
  wire rd_ans = avs_read_i && !avs_waitrequest_o;
  wire pop_ans = rd_ans && avs_address_i == `OFS_RX_DATA;
  a_wait_one: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("request not answered after one wait state");
  a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  a_no_spur: assert property (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
    else $error("answer without request");
  // reset itself must not be masked here
  a_rst_state: assert property (disable iff (1'b0) sys_rst_i |=> avs_waitrequest_o && rx_empty_o)
    else $error("wrong state after reset");
  a_int_rsv: assert property (rd_ans && avs_address_i == `OFS_DIV_INTEGER |-> avs_readdata_o[31:16] == 16'h0000)
    else $error("integer divisor reserved bits set");
  a_frac_rsv: assert property (rd_ans && avs_address_i == `OFS_DIV_FRACTION |-> avs_readdata_o[31:6] == 26'h0)
    else $error("fraction divisor reserved bits set");
  a_lc_rsv: assert property (rd_ans && avs_address_i == `OFS_RX_LINE_CONTROL |-> avs_readdata_o[31:8] == 24'h0 && !avs_readdata_o[0])
    else $error("line control reserved bits set");
  a_unmapped: assert property (rd_ans && avs_address_i == 6'h3C |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  // empty only comes back through a data pop
  a_empty_rise: assert property ($rose(rx_empty_o) |-> $past(pop_ans) || $past(pop_ans, 2))
    else $error("empty flag rose without a pop");
endmodule
`default_nettype wire

// file: testbench/uart_rx_frame_and_baud_divider_tb.sv
// self-checking bench: registers over avalon-mm, frames from the remote model
// assumes one 100 MHz clock and synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_defs.vh"
module uart_rx_frame_and_baud_divider_tb;
  logic clock_i, sys_rst_i, avs_read_i, avs_write_i;
  logic [5:0] avs_address_i;
  logic [3:0] avs_byteenable_i;
  logic [31:0] avs_writedata_i;
  wire [31:0] avs_readdata_o;
  wire avs_waitrequest_o, rx_empty_o, rx_serial_i;
  int errors = 0;
  int cmp_count = 0;
  integer seed = 18600;
  logic [31:0] exp_q[$];
  uart_rx_frame_and_baud_divider u_uart_rx_frame_and_baud_divider (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .rx_serial_i(rx_serial_i), .rx_empty_o(rx_empty_o));
  uart_tx_model u_uart_tx_model (.clock_i(clock_i), .serial_o(rx_serial_i));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic chk(input string what, input [31:0] seen, input [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task close_out;
    if (errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // bus cycles: one idle edge first so release and raise never share a step
  // ----------------------------------------
  task automatic bus(input bit w, input [5:0] a, input [31:0] d, input [3:0] be, output [31:0] q);
    begin
      @(posedge clock_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_byteenable_i <= be;
      avs_write_i <= w;
      avs_read_i <= !w;
      @(posedge clock_i);
      // no cycle count assumed: only the watchdog ends a wait
      while (avs_waitrequest_o !== 1'b0) begin
        @(posedge clock_i);
      end
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
    end
  endtask
  task automatic wr(input [5:0] a, input [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask
  task automatic rd(input [5:0] a, output [31:0] q);
    bus(1'b0, a, 32'h0, 4'hF, q);
  endtask
  // ----------------------------------------
  // reference model of one frame
  // ----------------------------------------
  task automatic frame(input [7:0] lc, input int bt, input bit pe, input bit fe, input [7:0] d);
    int nb;
    bit par;
    logic [7:0] dm;
    begin
      nb = 5 + lc[6:5];
      dm = d & 8'((1 << nb) - 1);
      par = lc[7] ? !lc[2] : (lc[2] ? ^dm : !(^dm));
      exp_q.push_back({22'h0, lc[1] & pe, fe, dm});
      u_uart_tx_model.send(bt, nb, dm, lc[1], par ^ pe, 1 + lc[3], fe);
    end
  endtask
  task automatic take(input bit more);
    logic [31:0] q;
    int n;
    begin
      n = 0;
      while (rx_empty_o !== 1'b0 && n < 2000) begin
        n++;
        @(posedge clock_i);
      end
      chk("rx_empty_o", rx_empty_o, 32'h0);
      rd(`OFS_RX_DATA, q);
      chk("rx_data", q, exp_q.pop_front());
      repeat (3) @(posedge clock_i);
      chk("rx_empty_o", rx_empty_o, !more);
    end
  endtask
  initial begin
    #1000000;
    errors++;
    close_out;
  end
  initial begin
    logic [31:0] q, r;
    logic [7:0] lc;
    logic [5:0] ofs [4];
    int i;
    ofs = '{`OFS_RX_LINE_CONTROL, `OFS_DIV_INTEGER, `OFS_DIV_FRACTION, 6'h3C};
    sys_rst_i = 1'b1;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 6'h00;
    avs_byteenable_i = 4'h0;
    avs_writedata_i = 32'h0;
    repeat (12) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    for (i = 0; i < 4; i++) begin
      rd(ofs[i], q);
      chk("reset value", q, 32'h0);
    end
    rd(`OFS_STATUS, q);
    chk("status empty", q[`ST_RX_EMPTY], 32'h1);
    wr(`OFS_DIV_INTEGER, 32'hFFFFFFFF);
    rd(`OFS_DIV_INTEGER, q);
    chk("div_integer", q, 32'h0000FFFF);
    bus(1'b1, `OFS_DIV_INTEGER, 32'h000055AA, 4'h1, q);
    rd(`OFS_DIV_INTEGER, q);
    chk("div_integer lane", q, 32'h0000FFAA);
    wr(`OFS_DIV_FRACTION, 32'hFFFFFFFF);
    rd(`OFS_DIV_FRACTION, q);
    chk("div_fraction", q, 32'h0000003F);
    r = $random(seed);
    wr(`OFS_RX_LINE_CONTROL, r);
    rd(`OFS_RX_LINE_CONTROL, q);
    chk("line_control", q, r & 32'hFE);
    wr(6'h3C, 32'hFFFFFFFF);
    rd(6'h3C, q);
    chk("unmapped", q, 32'h0);
    wr(`OFS_DIV_INTEGER, 32'h4);
    wr(`OFS_DIV_FRACTION, 32'h0);
    // every word length, stop count, parity mode, random faults
    for (i = 0; i < 32; i++) begin
      r = $random(seed);
      lc = {r[0], i[1:0], 1'b0, i[2], i[3], i[4], 1'b0};
      wr(`OFS_RX_LINE_CONTROL, {24'h0, lc});
      frame(lc, 64, r[1], r[2] & r[3], r[15:8]);
      take(1'b0);
    end
    lc = 8'h60;
    wr(`OFS_RX_LINE_CONTROL, {24'h0, lc});
    wr(`OFS_DIV_FRACTION, 32'd32);
    frame(lc, 72, 1'b0, 1'b0, 8'h55);
    take(1'b0);
    wr(`OFS_DIV_FRACTION, 32'h0);
    wr(`OFS_UART_CONTROL, 32'h1);
    frame(lc, 32, 1'b0, 1'b0, 8'hA6);
    take(1'b0);
    wr(`OFS_UART_CONTROL, 32'h0);
    // divisor written mid-frame: old rate holds until the frame ends
    fork
      frame(lc, 64, 1'b0, 1'b0, 8'hA5);
      begin
        repeat (300) @(posedge clock_i);
        wr(`OFS_DIV_INTEGER, 32'h2);
      end
    join
    take(1'b0);
    frame(lc, 32, 1'b0, 1'b0, 8'h3C);
    take(1'b0);
    wr(`OFS_RX_LINE_CONTROL, 32'h70);
    for (i = 0; i < 3; i++) frame(8'h70, 32, 1'b0, 1'b0, 8'($random(seed)));
    take(1'b1);
    take(1'b1);
    take(1'b0);
    // character mode keeps one word, the second is lost
    wr(`OFS_RX_LINE_CONTROL, 32'h60);
    frame(lc, 32, 1'b0, 1'b0, 8'h11);
    frame(lc, 32, 1'b0, 1'b0, 8'h22);
    take(1'b0);
    void'(exp_q.pop_back());
    rd(`OFS_RX_DATA, q);
    chk("empty read", q, 32'h0);
    close_out;
  end
endmodule
bind uart_rx_frame_and_baud_divider uart_rx_checker u_uart_rx_checker (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .rx_empty_o(rx_empty_o));
`default_nettype wire

// file: testbench/uart_tx_model.sv
// remote transmitter: sends one frame per call of send
// assumes bit time given in clock cycles; line idles high
`timescale 1ns/1ps
`default_nettype none
module uart_tx_model (
  input wire logic clock_i,
  output logic serial_o
);
  initial serial_o = 1'b1;
  task automatic bit_out(input int bt, input bit v);
    begin
      @(posedge clock_i);
      serial_o <= v;
      repeat (bt - 1) @(posedge clock_i);
    end
  endtask
  // start, data lsb first, parity, stops; bad stop forces last stop low
  task automatic send(input int bt, input int nb, input int d, input bit pen, input bit pb, input int ns,
                      input bit bad);
    int i;
    begin
      bit_out(bt, 1'b0);
      for (i = 0; i < nb; i++) bit_out(bt, d[i]);
      if (pen) bit_out(bt, pb);
      for (i = 0; i < ns; i++) bit_out(bt, !(bad && i == ns - 1));
      bit_out(bt, 1'b1);
    end
  endtask
endmodule
`default_nettype wire
